// ==== rtl/dpr_power_id_regs.v ====
// Power-down and identity register bank of a four-channel converter.
// Assumes the serial port front end presents decoded byte writes and reads
// in the i_clk_sys domain; the transmit-enable pins are asynchronous.
// Notes on behaviour
// RULE1: Two-bit link page select; 1 first link, 2 second, resets to 3.
// RULE2: Power bit 7 powers down reference regardless of masking; resets 1.
// RULE3: Power bit 6 set powers down channel 0, overriding masked control.
// RULE4: Power bit 5 set powers down channel 1, overriding masked control.
// RULE5: Power bit 4 set powers down channel 2, overriding masked control.
// RULE6: Power bit 3 set powers down channel 3, overriding masked control.
// RULE7: Channel bit 0 enables channel; all channel bits reset to 1.
// RULE8: Mask bit 7 with transmit pin 1 low powers down channels 2, 3.
// RULE9: Mask bit 6 with transmit pin 0 low powers down channels 0, 1.
// RULE10: Mask bit clear ignores its transmit pin; individual bits rule.
// RULE11: Reserved bits read zero and writes to them do nothing.
`include "dpr_regs.vh"

module dpr_power_id_regs #(
    parameter [7:0] PRODUCT_ID_LOW = 8'h00,  // Arbitrary neutral value.
    parameter [7:0] PRODUCT_ID_HIGH = 8'h00, // Arbitrary neutral value.
    parameter [3:0] PRODUCT_GRADE = 4'h0,    // Arbitrary neutral value.
    parameter [3:0] SILICON_REVISION = 4'h0  // Arbitrary neutral value.
) (
    // Clock and reset
    input wire i_clk_sys,
    input wire i_resetn,
    // Register port
    input wire [11:0] i_addr,
    input wire i_wr_en,
    input wire [7:0] i_wr_data,
    input wire i_rd_en,
    output reg [7:0] o_rd_data,
    // Transmit-enable pins
    input wire i_transmit_enable_pin_0,
    input wire i_transmit_enable_pin_1,
    // Power-down controls and page select
    output reg [1:0] o_link_page_select,
    output reg o_reference_powerdown,
    output reg [3:0] o_channel_powerdown
);

    // Widths of the stored parts of each register and of the pin filter.
    localparam PAGE_W = 2;
    localparam PWR_W = 5;
    localparam MASK_W = 2;
    localparam CHANNELS = 4;
    localparam PAIRS = 2;
    localparam PINS = 2;
    localparam SYNC_STAGES = `DPR_SYNC_STAGES;

    // Stored fields; the power field keeps the reference in bit 4 and
    // channels 0 to 3 in bits 3 down to 0. Mask bit 1 gates pair 2/3.
    reg [PAGE_W-1:0] link_page_reg;
    reg [PAGE_W-1:0] link_page_next;
    reg [PWR_W-1:0] power_ctrl_reg;
    reg [PWR_W-1:0] power_ctrl_next;
    reg [MASK_W-1:0] tx_mask_reg;
    reg [MASK_W-1:0] tx_mask_next;

    // Decoded write strobes and read data.
    reg wr_page;
    reg wr_power;
    reg wr_mask;
    reg [7:0] rd_next;

    // Filtered pin levels, pair gates and per-channel power-down.
    wire [PINS-1:0] pin_raw;
    wire [PINS-1:0] pin_level;
    wire [PAIRS-1:0] pair_gate;
    wire [CHANNELS-1:0] chan_pd_next;

    // Write decode; a write to any other address changes nothing.
    always @* begin
        wr_page = 1'b0;
        wr_power = 1'b0;
        wr_mask = 1'b0;
        if (i_wr_en) begin
            if (i_addr == `DPR_ADDR_LINK_PAGE) begin
                wr_page = 1'b1;
            end else if (i_addr == `DPR_ADDR_POWER_CTRL) begin
                wr_power = 1'b1;
            end else if (i_addr == `DPR_ADDR_TX_MASK) begin
                wr_mask = 1'b1;
            end
        end
    end

    // Next values; only defined bits are taken from the write data.
    always @* begin
        link_page_next = link_page_reg;
        power_ctrl_next = power_ctrl_reg;
        tx_mask_next = tx_mask_reg;
        if (wr_page) begin
            link_page_next = i_wr_data[`DPR_BIT_PAGE_HI:
                                       `DPR_BIT_PAGE_LO]; // RULE1 RULE11
        end
        if (wr_power) begin
            power_ctrl_next = i_wr_data[`DPR_BIT_REF_PD:
                                        `DPR_BIT_CH3_PD]; // RULE11
        end
        if (wr_mask) begin
            tx_mask_next = i_wr_data[`DPR_BIT_PAIR23_MASK:
                                     `DPR_BIT_PAIR01_MASK]; // RULE11
        end
    end

    // Page pointer; value 0 is stored although it selects no link.
    always @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            link_page_reg <= `DPR_RST_LINK_PAGE; // RULE1
        end else begin
            link_page_reg <= link_page_next;
        end
    end

    // Power field; the reference and every channel start powered down.
    always @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            power_ctrl_reg <= `DPR_RST_POWER_CTRL; // RULE2 RULE7
        end else begin
            power_ctrl_reg <= power_ctrl_next;
        end
    end

    // Pair masks start clear, so the pins are ignored after reset.
    always @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            tx_mask_reg <= `DPR_RST_TX_MASK; // RULE10
        end else begin
            tx_mask_reg <= tx_mask_next;
        end
    end

    // Pins cross from outside the clock domain through three stages; a
    // level counts once the last two agree, which also rejects glitches.
    assign pin_raw = {i_transmit_enable_pin_1, i_transmit_enable_pin_0};

    genvar pn;
    generate
        for (pn = 0; pn < PINS; pn = pn + 1) begin : g_pin
            reg [SYNC_STAGES-1:0] sync_reg;
            reg level_reg;
            always @(posedge i_clk_sys or negedge i_resetn) begin
                if (!i_resetn) begin
                    sync_reg <= {SYNC_STAGES{1'b0}};
                    level_reg <= 1'b0;
                end else begin
                    sync_reg <= {sync_reg[SYNC_STAGES-2:0], pin_raw[pn]};
                    if (sync_reg[SYNC_STAGES-2] == sync_reg[SYNC_STAGES-1]) begin
                        level_reg <= sync_reg[SYNC_STAGES-1];
                    end
                end
            end
            assign pin_level[pn] = level_reg;
        end
    endgenerate

    // A pair is gated only while its mask is set and its pin is low.
    genvar pr;
    generate
        for (pr = 0; pr < PAIRS; pr = pr + 1) begin : g_pair
            assign pair_gate[pr] = tx_mask_reg[pr]
                                   & ~pin_level[pr]; // RULE8 RULE9 RULE10
        end
    endgenerate

    // Channel bits are OR-ed with the pair gate, so a set bit always wins;
    // channel 0 sits in the highest stored channel bit.
    genvar ch;
    generate
        for (ch = 0; ch < CHANNELS; ch = ch + 1) begin : g_chan
            assign chan_pd_next[ch] = power_ctrl_reg[CHANNELS-1-ch] // RULE5 RULE6
                                      | pair_gate[ch/2]; // RULE3 RULE4
        end
    endgenerate

    // Read mux; unmapped addresses and reserved bits read zero.
    always @* begin
        rd_next = 8'h00;
        if (i_addr == `DPR_ADDR_PROD_ID_LOW) begin
            rd_next = PRODUCT_ID_LOW;
        end else if (i_addr == `DPR_ADDR_PROD_ID_HIGH) begin
            rd_next = PRODUCT_ID_HIGH;
        end else if (i_addr == `DPR_ADDR_GRADE_REV) begin
            rd_next = {PRODUCT_GRADE, SILICON_REVISION};
        end else if (i_addr == `DPR_ADDR_LINK_PAGE) begin
            rd_next = {6'h00, link_page_reg}; // RULE11
        end else if (i_addr == `DPR_ADDR_POWER_CTRL) begin
            rd_next = {power_ctrl_reg, 3'h0}; // RULE11
        end else if (i_addr == `DPR_ADDR_TX_MASK) begin
            rd_next = {tx_mask_reg, 6'h00}; // RULE11
        end
    end

    // Read data is registered and holds until the next read strobe.
    always @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            o_rd_data <= `DPR_RST_RD_DATA;
        end else if (i_rd_en) begin
            o_rd_data <= rd_next;
        end
    end

    // The page output trails the stored field by one edge.
    always @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            o_link_page_select <= `DPR_RST_LINK_PAGE;
        end else begin
            o_link_page_select <= link_page_reg; // RULE1
        end
    end

    // The reference never looks at the pins or the pair masks.
    always @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            o_reference_powerdown <= `DPR_RST_REF_PD;
        end else begin
            o_reference_powerdown <= power_ctrl_reg[PWR_W-1]; // RULE2
        end
    end

    // Channel outputs are registered so the pins cannot glitch them.
    always @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            o_channel_powerdown <= `DPR_RST_CHAN_PD;
        end else begin
            o_channel_powerdown <= chan_pd_next; // RULE7
        end
    end

endmodule // dpr_power_id_regs

// ==== rtl/dpr_regs.vh ====
// Register map constants for the converter power and identity register bank.
// Assumes byte-wide registers on a 12-bit serial register port address.
`ifndef DPR_REGS_VH
`define DPR_REGS_VH
`define DPR_ADDR_PROD_ID_LOW 12'h004
`define DPR_ADDR_PROD_ID_HIGH 12'h005
`define DPR_ADDR_GRADE_REV 12'h006
`define DPR_ADDR_LINK_PAGE 12'h008
`define DPR_ADDR_POWER_CTRL 12'h011
`define DPR_ADDR_TX_MASK 12'h012
`define DPR_RST_LINK_PAGE 2'h3
`define DPR_RST_POWER_CTRL 5'h1f
`define DPR_RST_TX_MASK 2'h0
`define DPR_BIT_REF_PD 7
`define DPR_RST_REF_PD 1'h1
`define DPR_RST_CHAN_PD 4'hf
`define DPR_RST_RD_DATA 8'h00
`define DPR_BIT_PAGE_HI 1
`define DPR_BIT_PAGE_LO 0
`define DPR_BIT_CH0_PD 6
`define DPR_BIT_CH1_PD 5
`define DPR_BIT_CH2_PD 4
`define DPR_BIT_CH3_PD 3
`define DPR_SYNC_STAGES 3
`define DPR_BIT_PAIR23_MASK 7
`define DPR_BIT_PAIR01_MASK 6
`endif

// ==== dv/dpr_monitor.sv ====
// Port checker for the converter power and identity register bank.
// Assumes one clock domain and the two-edge write-to-output latency.
module dpr_monitor (
    input wire i_clk_sys, input wire i_resetn, input wire [11:0] i_addr,
    input wire i_wr_en, input wire [7:0] i_wr_data, input wire i_rd_en,
    input wire [7:0] o_rd_data, input wire i_transmit_enable_pin_0,
    input wire i_transmit_enable_pin_1, input wire [1:0] o_link_page_select,
    input wire o_reference_powerdown, input wire [3:0] o_channel_powerdown
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_resetn);
    sequence s_pwr_wr;
        i_wr_en && i_addr == 12'h011;
    endsequence
    chk_ref_follows_bit: assert property (s_pwr_wr |-> ##2
        o_reference_powerdown == $past(i_wr_data[7], 2)) else $error("ref");
    chk_ch0_forced_down: assert property (s_pwr_wr ##0 i_wr_data[6]
        |-> ##2 o_channel_powerdown[0]) else $error("ch0");
    chk_ch1_forced_down: assert property (s_pwr_wr ##0 i_wr_data[5]
        |-> ##2 o_channel_powerdown[1]) else $error("ch1");
    chk_ch2_forced_down: assert property (s_pwr_wr ##0 i_wr_data[4]
        |-> ##2 o_channel_powerdown[2]) else $error("ch2");
    chk_ch3_forced_down: assert property (s_pwr_wr ##0 i_wr_data[3]
        |-> ##2 o_channel_powerdown[3]) else $error("ch3");
    chk_page_follows_wr: assert property (i_wr_en && i_addr == 12'h008
        |-> ##2 o_link_page_select == $past(i_wr_data[1:0], 2))
        else $error("pg");
    chk_pwr_rsvd_zero: assert property (i_rd_en && i_addr == 12'h011
        |=> o_rd_data[2:0] == 3'h0) else $error("reserved bits");
    chk_unmapped_zero: assert property (i_rd_en && i_addr > 12'h012
        |=> o_rd_data == 8'h00) else $error("unmapped read");
endmodule // dpr_monitor

// ==== dv/dpr_host.sv ====
// Host model that reaches the register bank through its byte port.
// Released data lines show the inverse so stale values cannot pass.
module dpr_host (
    input wire i_clk_sys, input wire [7:0] i_rd_data,
    output logic [11:0] o_addr = 12'h000, output logic o_wr_en = 1'b0,
    output logic o_rd_en = 1'b0, output logic [7:0] o_wr_data = 8'h00
);
    timeunit 1ns;
    timeprecision 1ns;
    task wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge i_clk_sys); o_addr <= a; o_wr_data <= d; o_wr_en <= 1'b1;
        @(posedge i_clk_sys); o_wr_en <= 1'b0; o_wr_data <= ~d;
    endtask
    task rd(input logic [11:0] a, output logic [7:0] d);
        @(posedge i_clk_sys); o_addr <= a; o_rd_en <= 1'b1;
        @(posedge i_clk_sys); o_rd_en <= 1'b0; o_addr <= ~a;
        @(posedge i_clk_sys); #1 d = i_rd_data;
    endtask
endmodule // dpr_host

// ==== dv/test_dac_power_id_registers.sv ====
// Self-checking bench for the power and identity register bank.
// Identity parameters are arbitrary values chosen for this bench.
module test_dac_power_id_registers;
    timeunit 1ns;
    timeprecision 1ns;
    logic i_clk_sys = 0, i_resetn = 0, p0 = 1, p1 = 1, rp;
    logic [11:0] addr, ra[7] = '{12'h004, 12'h005, 12'h006, 12'h008,
        12'h011, 12'h012, 12'h013};
    logic [7:0] wd, rdata, v, re[7] = '{8'h5a, 8'h3c, 8'h27, 8'h03, 8'hf8,
        8'h00, 8'h00};
    logic wr, rd;
    logic [1:0] pg;
    logic [3:0] ch;
    int miscompares = 0, n_checks = 0;
    initial forever #25 i_clk_sys = ~i_clk_sys;
    dpr_host host (.i_clk_sys(i_clk_sys), .i_rd_data(rdata), .o_addr(addr),
        .o_wr_en(wr), .o_rd_en(rd), .o_wr_data(wd));
    dpr_power_id_regs #(.PRODUCT_ID_LOW(8'h5a), .PRODUCT_ID_HIGH(8'h3c),
        .PRODUCT_GRADE(4'h2), .SILICON_REVISION(4'h7)) dut (
        .i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_addr(addr),
        .i_wr_en(wr), .i_wr_data(wd), .i_rd_en(rd), .o_rd_data(rdata),
        .i_transmit_enable_pin_0(p0), .i_transmit_enable_pin_1(p1),
        .o_link_page_select(pg), .o_reference_powerdown(rp),
        .o_channel_powerdown(ch));
    task chk(input logic [7:0] got, exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // Outputs packed as page, reference, zero, channels; pins need 5 edges.
    task outs(input logic [7:0] e);
        repeat (6) @(posedge i_clk_sys);
        #1 chk({pg, rp, 1'b0, ch}, e);
    endtask
    task t_reset;
        for (int i = 0; i < 7; i++) begin
            host.rd(ra[i], v);
            chk(v, re[i]);
        end
        outs(8'hef);
    endtask
    task t_power;
        host.wr(12'h011, 8'h57);
        outs(8'hc5);
        host.rd(12'h011, v);
        chk(v, 8'h50);
        host.wr(12'h011, 8'h88);
        outs(8'he8);
    endtask
    task t_mask;
        host.wr(12'h011, 8'h00);
        host.wr(12'h012, 8'hff);
        host.rd(12'h012, v);
        chk(v, 8'hc0);
        outs(8'hc0);
        @(posedge i_clk_sys) p0 <= 1'b0;
        outs(8'hc3);
        @(posedge i_clk_sys) p1 <= 1'b0;
        outs(8'hcf);
        host.wr(12'h012, 8'h80);
        outs(8'hcc);
        host.wr(12'h012, 8'h00);
        outs(8'hc0);
    endtask
    task t_page;
        host.wr(12'h008, 8'h01);
        outs(8'h40);
        host.wr(12'h008, 8'hfe);
        host.wr(12'h004, 8'hff);
        host.rd(12'h008, v);
        chk(v, 8'h02);
        host.rd(12'h004, v);
        chk(v, 8'h5a);
    endtask
    task summarize;
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge i_clk_sys);
        i_resetn <= 1'b1;
        t_reset;
        t_power;
        t_mask;
        t_page;
        summarize;
    end
    initial begin
        #100000;
        miscompares++;
        summarize;
    end
endmodule // test_dac_power_id_registers
bind dpr_power_id_regs dpr_monitor mon (
    .i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_addr(i_addr),
    .i_wr_en(i_wr_en), .i_wr_data(i_wr_data), .i_rd_en(i_rd_en),
    .o_rd_data(o_rd_data),
    .i_transmit_enable_pin_0(i_transmit_enable_pin_0),
    .i_transmit_enable_pin_1(i_transmit_enable_pin_1),
    .o_link_page_select(o_link_page_select),
    .o_reference_powerdown(o_reference_powerdown),
    .o_channel_powerdown(o_channel_powerdown));
